// [rtl/sfa_pkg.sv]
// Constants, opcodes and register map of the status-flag and operand-address block.
// Assumes an APB master on pclk with 32-bit data and word-aligned byte addresses.
// How it works
// - Flag-affecting result aimed at status register is dropped; only new flags land.
// - Clearing the status register sets only the zero flag, other flags unchanged.
// - Bit set/clear, swap, work-to-file and file-to-file moves leave all five arithmetic flags alone.
// - Status is eight bits; top three read zero; five flags are read/write.
// - Negative flag in bit 4 copies the result's top bit.
// - Overflow flag in bit 3 marks a wrong sign change of a signed result.
// - Zero flag in bit 2 is set when a flag-affecting result is zero.
// - Add and subtract load nibble carry in bit 1 from the low nibble carry.
// - Add and subtract load carry in bit 0 from the top-bit carry.
// - Subtract adds the two's complement, so carry flags mean no borrow.
// - Rotates load nibble carry from source bit 4 or 3, carry from end bit.
// - With access bit one, bank select and opcode byte form a 12-bit address.
// - With access bit zero, opcode byte addresses the access bank, bank ignored.
// - File-to-file move uses its full 12-bit address and ignores bank select.
// - Destination bit one writes the file, zero writes working; else implicit.
// - Call and jump take a 20-bit program address from the opcode.
// - Three pointer pairs, upper high-byte nibble unused, each a 12-bit address.
// - Virtual indirect operands have no storage; they reach the pointed location.
// - Indirect targets use the whole pointer; bank select and access bit ignored.
// - Indexed literal offset mode exists only when extended ISA enable is one.
// - Post-increment, post-decrement, pre-increment step the pointer by one.
// - Offset-by-working adds signed working value, changing neither register.
// - Pointer steps carry across the whole 12-bit pair and touch no flags.
package sfa_pkg;
    // Register byte offsets
    localparam logic [11:0] REG_FLAGS = 12'h000;
    localparam logic [11:0] REG_WORK = 12'h004;
    localparam logic [11:0] REG_BANK = 12'h008;
    localparam logic [11:0] REG_PTR0 = 12'h00C;
    localparam logic [11:0] REG_PTR1 = 12'h010;
    localparam logic [11:0] REG_PTR2 = 12'h014;
    localparam logic [11:0] REG_OPERAND = 12'h018;
    localparam logic [11:0] REG_CONFIG = 12'h01C;
    localparam logic [11:0] REG_CMD = 12'h020;
    localparam logic [11:0] REG_RESULT = 12'h024;
    localparam logic [11:0] REG_TARGET = 12'h028;
    localparam logic [11:0] REG_PROG = 12'h02C;
    // Reset values
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [11:0] PTR_RST = 12'h000;
    // Flag positions
    localparam int FLAG_N = 4;
    localparam int FLAG_OV = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_DC = 1;
    localparam int FLAG_C = 0;
    // Data memory map
    localparam logic [11:0] STATUS_ADDR = 12'hFD8;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [11:0] VIRT_BASE0 = 12'hFEF;
    localparam logic [11:0] VIRT_BASE1 = 12'hFE7;
    localparam logic [11:0] VIRT_BASE2 = 12'hFDF;
    // Offsets below a virtual base: plain, post-inc, post-dec, pre-inc, plus-working
    localparam logic [11:0] VK_PLAIN = 12'h000;
    localparam logic [11:0] VK_POST_INCREMENT_OPERAND = 12'h001;
    localparam logic [11:0] VK_POST_DECREMENT_OPERAND = 12'h002;
    localparam logic [11:0] VK_PRE_INCREMENT_OPERAND = 12'h003;
    localparam logic [11:0] VK_OFFSET_BY_WORKING_OPERAND = 12'h004;
    // Command word fields
    localparam int CMD_D_BIT = 5;
    localparam int CMD_A_BIT = 6;
    localparam int CMD_F_LSB = 8;
    localparam int CMD_SRC_LSB = 8;
    localparam int CMD_DST_LSB = 20;
    localparam int CMD_BIT_LSB = 28;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD_WORK_FILE = 5'h01, OP_ADD_LIT = 5'h02, OP_SUB_WORK_FILE = 5'h03,
        OP_SUB_LIT = 5'h04, OP_AND_FILE = 5'h05, OP_IOR_FILE = 5'h06, OP_XOR_FILE = 5'h07,
        OP_MOVE_FILE = 5'h08, OP_CLEAR_FILE = 5'h09, OP_BIT_CLEAR = 5'h0A, OP_BIT_SET = 5'h0B,
        OP_NIBBLE_SWAP = 5'h0C, OP_WORK_TO_FILE = 5'h0D, OP_FILE_TO_FILE = 5'h0E,
        OP_ROTATE_RIGHT = 5'h0F, OP_ROTATE_LEFT = 5'h10, OP_CALL = 5'h11, OP_JUMP = 5'h12
    } sfa_op_t;
endpackage : sfa_pkg

// [rtl/sfa_core.sv]
// Status flag generation and data operand address generation, APB slave.
// Assumes software stages working value, operand byte and pointers, then writes a command.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module sfa_core (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [4:0] flags_q;
    logic [7:0] work_q;
    logic [3:0] bank_q;
    logic [11:0] ptr_q [3];
    logic [7:0] operand_q;
    logic extended_isa_enable_q;
    logic [7:0] result_q;
    logic [15:0] target_q;
    logic [19:0] prog_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    logic wr_fire;
    logic rd_take;
    logic exec;
    logic mapped;
    logic [31:0] rd_data;

    // Command decode
    sfa_pkg::sfa_op_t op;
    logic [7:0] f_byte;
    logic uses_file;
    logic to_file;
    logic to_w;
    logic indexed;
    logic [11:0] direct_addr;
    logic [11:0] target_addr;
    logic virt_hit;
    logic [1:0] virt_ptr;
    logic [11:0] ptr_next;
    logic status_tgt;
    logic [4:0] mask;
    logic [12:0] alu_out;
    logic [4:0] merged;
    logic [4:0] flags_d;

    function automatic logic [4:0] flag_mask(input sfa_pkg::sfa_op_t o);
        case (o)
            sfa_pkg::OP_ADD_WORK_FILE, sfa_pkg::OP_ADD_LIT, sfa_pkg::OP_SUB_WORK_FILE, sfa_pkg::OP_SUB_LIT: begin
                flag_mask = 5'h1F;
            end
            sfa_pkg::OP_AND_FILE, sfa_pkg::OP_IOR_FILE, sfa_pkg::OP_XOR_FILE, sfa_pkg::OP_MOVE_FILE: begin
                flag_mask = 5'h14;
            end
            sfa_pkg::OP_CLEAR_FILE: begin
                flag_mask = 5'h04;
            end
            sfa_pkg::OP_ROTATE_RIGHT, sfa_pkg::OP_ROTATE_LEFT: begin
                flag_mask = 5'h17;
            end
            default: begin
                flag_mask = 5'h00;
            end
        endcase
    endfunction : flag_mask

    // Returns {N, OV, Z, DC, C, result}
    function automatic logic [12:0] alu(input sfa_pkg::sfa_op_t o, input logic [7:0] fv, input logic [7:0] w,
                                        input logic cin, input logic [2:0] bsel);
        logic sub;
        logic [7:0] addend;
        logic [4:0] lo;
        logic [8:0] sum;
        logic [7:0] r;
        logic dc;
        logic c;
        logic ov;
        sub = (o == sfa_pkg::OP_SUB_WORK_FILE) || (o == sfa_pkg::OP_SUB_LIT);
        addend = sub ? ~w : w;
        lo = {1'b0, fv[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
        sum = {1'b0, fv} + {1'b0, addend} + {8'h00, sub};
        r = sum[7:0];
        dc = lo[4];
        c = sum[8];
        ov = (fv[7] == addend[7]) && (sum[7] != fv[7]);
        case (o)
            sfa_pkg::OP_AND_FILE: begin
                r = fv & w;
            end
            sfa_pkg::OP_IOR_FILE: begin
                r = fv | w;
            end
            sfa_pkg::OP_XOR_FILE: begin
                r = fv ^ w;
            end
            sfa_pkg::OP_MOVE_FILE, sfa_pkg::OP_FILE_TO_FILE: begin
                r = fv;
            end
            sfa_pkg::OP_CLEAR_FILE: begin
                r = 8'h00;
            end
            sfa_pkg::OP_BIT_CLEAR: begin
                r = fv & ~(8'h01 << bsel);
            end
            sfa_pkg::OP_BIT_SET: begin
                r = fv | (8'h01 << bsel);
            end
            sfa_pkg::OP_NIBBLE_SWAP: begin
                r = {fv[3:0], fv[7:4]};
            end
            sfa_pkg::OP_WORK_TO_FILE: begin
                r = w;
            end
            sfa_pkg::OP_ROTATE_RIGHT: begin
                r = {cin, fv[7:1]};
                c = fv[0];
                dc = fv[4];
            end
            sfa_pkg::OP_ROTATE_LEFT: begin
                r = {fv[6:0], cin};
                c = fv[7];
                dc = fv[3];
            end
            default: begin
                r = sum[7:0];
            end
        endcase
        alu = {r[7], ov, (r == 8'h00), dc, c, r};
    endfunction : alu

    function automatic logic [11:0] virt_base(input logic [1:0] n);
        case (n)
            2'd0: begin
                virt_base = sfa_pkg::VIRT_BASE0;
            end
            2'd1: begin
                virt_base = sfa_pkg::VIRT_BASE1;
            end
            default: begin
                virt_base = sfa_pkg::VIRT_BASE2;
            end
        endcase
    endfunction : virt_base

    // APB handshake: one wait state so read data comes from a flop
    assign rd_take = psel && penable && !pready_q;
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign exec = wr_fire && (paddr == sfa_pkg::REG_CMD);

    always_comb begin
        mapped = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr)
            sfa_pkg::REG_FLAGS: begin
                rd_data = {27'h000_0000, flags_q};
            end
            sfa_pkg::REG_WORK: begin
                rd_data = {24'h00_0000, work_q};
            end
            sfa_pkg::REG_BANK: begin
                rd_data = {28'h000_0000, bank_q};
            end
            sfa_pkg::REG_PTR0: begin
                rd_data = {20'h0_0000, ptr_q[0]};
            end
            sfa_pkg::REG_PTR1: begin
                rd_data = {20'h0_0000, ptr_q[1]};
            end
            sfa_pkg::REG_PTR2: begin
                rd_data = {20'h0_0000, ptr_q[2]};
            end
            sfa_pkg::REG_OPERAND: begin
                rd_data = {24'h00_0000, operand_q};
            end
            sfa_pkg::REG_CONFIG: begin
                rd_data = {31'h0000_0000, extended_isa_enable_q};
            end
            sfa_pkg::REG_CMD: begin
                rd_data = 32'h0000_0000;
            end
            sfa_pkg::REG_RESULT: begin
                rd_data = {24'h00_0000, result_q};
            end
            sfa_pkg::REG_TARGET: begin
                rd_data = {16'h0000, target_q};
            end
            sfa_pkg::REG_PROG: begin
                rd_data = {12'h000, prog_q};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= rd_take;
            pslverr_q <= rd_take && !mapped;
            if (rd_take && !pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end

    // Operand address generation
    always_comb begin
        op = sfa_pkg::sfa_op_t'(pwdata[4:0]);
        f_byte = pwdata[sfa_pkg::CMD_F_LSB +: 8];
        uses_file = 1'b1;
        to_file = pwdata[sfa_pkg::CMD_D_BIT];
        case (op)
            sfa_pkg::OP_NOP, sfa_pkg::OP_ADD_LIT, sfa_pkg::OP_SUB_LIT, sfa_pkg::OP_CALL, sfa_pkg::OP_JUMP: begin
                uses_file = 1'b0;
                to_file = 1'b0;
            end
            sfa_pkg::OP_CLEAR_FILE, sfa_pkg::OP_BIT_CLEAR, sfa_pkg::OP_BIT_SET, sfa_pkg::OP_WORK_TO_FILE,
            sfa_pkg::OP_FILE_TO_FILE: begin
                to_file = 1'b1;
            end
            default: begin
                to_file = pwdata[sfa_pkg::CMD_D_BIT];
            end
        endcase
        to_w = (uses_file && !to_file) || op == sfa_pkg::OP_ADD_LIT || op == sfa_pkg::OP_SUB_LIT;
        indexed = 1'b0;
        if (op == sfa_pkg::OP_FILE_TO_FILE) begin
            direct_addr = pwdata[sfa_pkg::CMD_DST_LSB +: 12];
        end else if (pwdata[sfa_pkg::CMD_A_BIT]) begin
            direct_addr = {bank_q, f_byte};
        end else if (uses_file && extended_isa_enable_q && f_byte <= sfa_pkg::INDEX_LIMIT) begin
            direct_addr = ptr_q[2] + {4'h0, f_byte};
            indexed = 1'b1;
        end else if (f_byte < sfa_pkg::ACCESS_SPLIT) begin
            direct_addr = {4'h0, f_byte};
        end else begin
            direct_addr = {sfa_pkg::ACCESS_HI_BANK, f_byte};
        end
        target_addr = direct_addr;
        virt_hit = 1'b0;
        virt_ptr = 2'd0;
        ptr_next = ptr_q[0];
        for (int n = 0; n < 3; n++) begin
            if (uses_file && !indexed && (virt_base(2'(n)) - direct_addr) <= sfa_pkg::VK_OFFSET_BY_WORKING_OPERAND) begin
                virt_hit = 1'b1;
                virt_ptr = 2'(n);
                ptr_next = ptr_q[n];
                target_addr = ptr_q[n];
                case (virt_base(2'(n)) - direct_addr)
                    sfa_pkg::VK_POST_INCREMENT_OPERAND: begin
                        ptr_next = ptr_q[n] + 12'h001;
                    end
                    sfa_pkg::VK_POST_DECREMENT_OPERAND: begin
                        ptr_next = ptr_q[n] - 12'h001;
                    end
                    sfa_pkg::VK_PRE_INCREMENT_OPERAND: begin
                        ptr_next = ptr_q[n] + 12'h001;
                        target_addr = ptr_q[n] + 12'h001;
                    end
                    sfa_pkg::VK_OFFSET_BY_WORKING_OPERAND: begin
                        target_addr = ptr_q[n] + {{4{work_q[7]}}, work_q};
                    end
                    default: begin
                        target_addr = ptr_q[n];
                    end
                endcase
            end
        end
        status_tgt = uses_file && to_file && (target_addr == sfa_pkg::STATUS_ADDR);
        mask = flag_mask(op);
        alu_out = alu(op, uses_file ? operand_q : f_byte, work_q, flags_q[sfa_pkg::FLAG_C],
                      pwdata[sfa_pkg::CMD_BIT_LSB +: 3]);
        merged = (flags_q & ~mask) | (alu_out[12:8] & mask);
        if (status_tgt && mask == 5'h00) begin
            flags_d = alu_out[4:0];
        end else begin
            flags_d = merged;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= sfa_pkg::FLAGS_RST;
        end else if (wr_fire && paddr == sfa_pkg::REG_FLAGS) begin
            flags_q <= pwdata[4:0];
        end else if (exec) begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_q <= sfa_pkg::BYTE_RST;
        end else if (wr_fire && paddr == sfa_pkg::REG_WORK) begin
            work_q <= pwdata[7:0];
        end else if (exec && to_w) begin
            work_q <= alu_out[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_q <= 4'h0;
            operand_q <= sfa_pkg::BYTE_RST;
            extended_isa_enable_q <= 1'b0;
        end else if (wr_fire) begin
            if (paddr == sfa_pkg::REG_BANK) begin
                bank_q <= pwdata[3:0];
            end
            if (paddr == sfa_pkg::REG_OPERAND) begin
                operand_q <= pwdata[7:0];
            end
            if (paddr == sfa_pkg::REG_CONFIG) begin
                extended_isa_enable_q <= pwdata[0];
            end
        end
    end

    // Pointer pairs; upper nibble of each high byte is not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < 3; n++) begin
                ptr_q[n] <= sfa_pkg::PTR_RST;
            end
        end else begin
            for (int n = 0; n < 3; n++) begin
                if (wr_fire && paddr == sfa_pkg::REG_PTR0 + 12'(4 * n)) begin
                    ptr_q[n] <= pwdata[11:0];
                end else if (exec && virt_hit && virt_ptr == 2'(n)) begin
                    ptr_q[n] <= ptr_next;
                end
            end
        end
    end

    // Outcome of the last command: result byte, where it goes, program target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= sfa_pkg::BYTE_RST;
            target_q <= 16'h0000;
            prog_q <= 20'h0_0000;
        end else if (exec) begin
            result_q <= alu_out[7:0];
            target_q <= {indexed, status_tgt && mask != 5'h00, to_w, to_file && !(status_tgt && mask != 5'h00),
                         uses_file ? target_addr : 12'h000};
            if (op == sfa_pkg::OP_CALL || op == sfa_pkg::OP_JUMP) begin
                prog_q <= pwdata[sfa_pkg::CMD_SRC_LSB +: 20];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule : sfa_core

// [dv/sfa_core_checker.sv]
// Protocol and register-shape assertions on the status-flag block's APB ports.
// Assumes one wait state per transfer and read data held between reads.
`timescale 1ns/10ps
module sfa_core_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic rd_done;
    assign rd_done = pready && !pwrite;
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held over one cycle");
    wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("pready not after one wait");
    setup_quiet_a: assert property (psel && !penable |=> !pready) else $error("pready in first access cycle");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    rdata_hold_a: assert property ($changed(prdata) |-> rd_done) else $error("prdata moved outside a read");
    err_rdata_zero_a: assert property (rd_done && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    flags_upper_zero_a: assert property (rd_done && paddr == sfa_pkg::REG_FLAGS |-> prdata[31:5] == 27'h000_0000)
        else $error("status upper bits not zero");
    ptr_upper_zero_a: assert property (rd_done && (paddr == sfa_pkg::REG_PTR0 || paddr == sfa_pkg::REG_PTR1
        || paddr == sfa_pkg::REG_PTR2) |-> prdata[31:12] == 20'h0_0000) else $error("pointer upper bits set");
    prog_width_a: assert property (rd_done && paddr == sfa_pkg::REG_PROG |-> prdata[31:20] == 12'h000)
        else $error("program address too wide");
endmodule : sfa_core_checker

bind sfa_core sfa_core_checker sfa_core_checker_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [dv/sfa_apb_host.sv]
// APB master standing in for the core sequencer that stages operands and issues commands.
// Assumes the bench holds req until done, then drops it.
`timescale 1ns/10ps
module sfa_apb_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench request
    input wire logic req,
    input wire logic req_write,
    input wire logic [11:0] req_addr,
    input wire logic [31:0] req_wdata,
    // Bench completion
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    // APB request
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                done <= 1'b1;
                rdata <= prdata;
                err <= pslverr;
                // Released lines show garbage
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (req && !done) begin
                psel <= 1'b1;
                paddr <= req_addr;
                pwrite <= req_write;
                pwdata <= req_wdata;
            end
        end
    end
endmodule : sfa_apb_host

// [dv/test_cpu_status_flags_and_data_addressing.sv]
// Self-checking bench: random commands against a reference of flags and addressing.
// Assumes the register map and command layout of sfa_pkg.
`timescale 1ns/10ps
module test_cpu_status_flags_and_data_addressing;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, req_write, done, err;
    logic [11:0] paddr, req_addr;
    logic [31:0] pwdata, prdata, req_wdata, rdata, c;
    int mismatches = 0, check_count = 0;
    logic [7:0] w_m, opnd_m, res_m;
    logic [4:0] fl_m;
    logic [3:0] bank_m;
    logic [11:0] ptr_m[3];
    logic cfg_m, lit_m, drop_m;
    logic [15:0] tgt_m;
    logic [19:0] prog_m = 20'h0_0000;
    logic [11:0] vbase[3] = '{sfa_pkg::VIRT_BASE0, sfa_pkg::VIRT_BASE1, sfa_pkg::VIRT_BASE2};

    sfa_core sfa_core_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sfa_apb_host sfa_apb_host_i (.pclk(pclk), .presetn(presetn), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rdata(rdata), .err(err), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic summarize();
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge pclk); while (done !== 1'b1);
        req <= 1'b0;
    endtask : bus

    task automatic rd(input logic [11:0] a, input string n, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(n, e, rdata);
        chk("slverr", 32'(a > sfa_pkg::REG_PROG), 32'(err));
    endtask : rd

    task automatic predict(input logic [31:0] c);
        logic [4:0] op, nf, h;
        logic [7:0] f, x, y, r;
        logic [8:0] s;
        logic [11:0] t;
        logic ix, sub, to_file, flop, stat;
        int n, kind;
        op = c[4:0];
        f = c[15:8];
        lit_m = op inside {5'h02, 5'h04, 5'h11, 5'h12};
        ix = 1'b0;
        kind = -1;
        n = 0;
        if (op == 5'h0E) t = c[31:20];
        else if (!lit_m && cfg_m && !c[6] && f <= 8'h5F) begin
            t = ptr_m[2] + {4'h0, f};
            ix = 1'b1;
        end else if (c[6]) t = {bank_m, f};
        else t = (f < 8'h60) ? {4'h0, f} : {4'hF, f};
        for (int i = 0; i < 3; i++)
            for (int k = 0; k < 5; k++)
                if (!ix && !lit_m && t == vbase[i] - 12'(k)) begin
                    n = i;
                    kind = k;
                end
        if (kind >= 0) begin
            t = (kind == 3) ? ptr_m[n] + 12'h001 : (kind == 4) ? ptr_m[n] + {{4{w_m[7]}}, w_m} : ptr_m[n];
            if (kind == 1 || kind == 3) ptr_m[n] = ptr_m[n] + 12'h001;
            if (kind == 2) ptr_m[n] = ptr_m[n] - 12'h001;
        end
        x = lit_m ? f : opnd_m;
        sub = op == 5'h03 || op == 5'h04;
        y = sub ? ~w_m : w_m;
        r = x;
        nf = fl_m;
        case (op)
            5'h01, 5'h02, 5'h03, 5'h04: begin
                s = x + y + sub;
                h = x[3:0] + y[3:0] + sub;
                r = s[7:0];
                nf = {r[7], x[7] == y[7] && r[7] != x[7], r == 8'h00, h[4], s[8]};
            end
            5'h05: r = w_m & x;
            5'h06: r = w_m | x;
            5'h07: r = w_m ^ x;
            5'h09: begin
                r = 8'h00;
                nf[2] = 1'b1;
            end
            5'h0A: r = x & ~(8'h01 << c[30:28]);
            5'h0B: r = x | (8'h01 << c[30:28]);
            5'h0C: r = {x[3:0], x[7:4]};
            5'h0D: r = w_m;
            5'h0F: begin
                r = {fl_m[0], x[7:1]};
                nf[1:0] = {x[4], x[0]};
            end
            5'h10: begin
                r = {x[6:0], fl_m[0]};
                nf[1:0] = {x[3], x[7]};
            end
            default: ;
        endcase
        if (op inside {[5'h05:5'h08], 5'h0F, 5'h10}) begin
            nf[4] = r[7];
            nf[2] = r == 8'h00;
        end
        flop = op inside {[5'h01:5'h09], 5'h0F, 5'h10};
        to_file = !lit_m && (op inside {5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0E} || c[5]);
        stat = to_file && t == sfa_pkg::STATUS_ADDR;
        drop_m = stat && flop;
        fl_m = (stat && !flop) ? r[4:0] : nf;
        if (!to_file && op < 5'h11) w_m = r;
        if (op > 5'h10) prog_m = c[27:8];
        tgt_m = {ix, drop_m, !to_file, to_file && !drop_m, t};
        res_m = r;
    endtask : predict

    task automatic run(input logic [31:0] c);
        logic [31:0] j, m;
        j = $urandom;
        // Junk above each field except the config bit must not be stored
        bus(1'b1, sfa_pkg::REG_FLAGS, {j[31:5], fl_m});
        bus(1'b1, sfa_pkg::REG_WORK, {j[31:8], w_m});
        bus(1'b1, sfa_pkg::REG_BANK, {j[31:4], bank_m});
        for (int p = 0; p < 3; p++) bus(1'b1, sfa_pkg::REG_PTR0 + 12'(4 * p), {j[31:12], ptr_m[p]});
        bus(1'b1, sfa_pkg::REG_OPERAND, {j[31:8], opnd_m});
        bus(1'b1, sfa_pkg::REG_CONFIG, {31'h0000_0000, cfg_m});
        bus(1'b1, sfa_pkg::REG_CMD, c);
        predict(c);
        if (!drop_m && c[4:0] < 5'h11) rd(sfa_pkg::REG_RESULT, "result", {24'h00_0000, res_m});
        if (c[4:0] < 5'h11) begin
            bus(1'b0, sfa_pkg::REG_TARGET, 32'h0000_0000);
            m = lit_m ? 32'h0000_F000 : 32'hFFFF_FFFF;
            chk("target", {16'h0000, tgt_m} & m, rdata & m);
        end
        rd(sfa_pkg::REG_FLAGS, "flags", {27'h000_0000, fl_m});
        rd(sfa_pkg::REG_WORK, "work", {24'h00_0000, w_m});
        for (int p = 0; p < 3; p++) rd(sfa_pkg::REG_PTR0 + 12'(4 * p), "pointer", {20'h0_0000, ptr_m[p]});
        rd(sfa_pkg::REG_PROG, "program address", {12'h000, prog_m});
    endtask : run

    initial begin
        presetn = 1'b0;
        req = 1'b0;
        void'($urandom(9));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) bus(1'b1, sfa_pkg::REG_RESULT + 12'(4 * i), 32'hFFFF_FFFF);
        for (int a = 0; a < 16; a++) rd(12'(4 * a), "reset value", 32'h0000_0000);
        rd(12'hFFC, "unmapped", 32'h0000_0000);
        for (int n = 0; n < 350; n++) begin
            c = $urandom;
            c[4:0] = 5'($urandom_range(18, 1));
            // Bias toward status, virtual operands and rollover
            case ($urandom_range(3))
                0: c[15:6] = {8'hD8, 1'b0, c[5]};
                1: begin
                    c[15:8] = 8'($urandom_range(8'hEF, 8'hDB));
                    c[31:20] = {4'hF, c[15:8]};
                end
                default: ;
            endcase
            bank_m = ($urandom_range(3) == 0) ? 4'hF : 4'($urandom);
            fl_m = 5'($urandom);
            w_m = 8'($urandom);
            opnd_m = 8'($urandom);
            cfg_m = 1'($urandom);
            for (int p = 0; p < 3; p++) begin
                ptr_m[p] = 12'($urandom);
                if ($urandom_range(1) == 1) ptr_m[p][7:0] = {8{ptr_m[p][0]}};
            end
            run(c);
        end
        summarize();
    end

    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        summarize();
    end
endmodule : test_cpu_status_flags_and_data_addressing
